// ==== rtl/cod_pkg.sv ====
// Purpose: constants and types for the comparator output debounce block
// Assumes: 32-bit APB register port, one system clock, async active-low reset
// Notes:   every offset, field position, reset value and run length lives here
//
// Function
// [RULE1] enable bit powers comparator; off forces result 0
// [RULE2] disabled: output flag equals polarity setting
// [RULE3] debounced output follows only after matching run
// [RULE4] debounce codes: none, 32, 64, 127 samples
// [RULE5] control bit 4 reads zero, ignores writes
// [RULE6] flag is positive-above-negative, optionally inverted
// [RULE7] status bits read-only; controls read-write, reset zero
package cod_pkg;

    // byte addresses of the two registers
    localparam logic [7:0] COD_OFS_CTRL = 8'h00;  // comparator1_control
    localparam logic [7:0] COD_OFS_CFG  = 8'h04;  // polarity configuration

    // comparator1_control field positions
    localparam int COD_OUT_BIT  = 7;  // polarity-adjusted flag, read only
    localparam int COD_EN_BIT   = 6;  // comparator enable
    localparam int COD_DEB_BIT  = 5;  // debounced flag, read only
    localparam int COD_RSVD_BIT = 4;  // unimplemented, reads zero
    localparam int COD_DSEL_LSB = 2;  // debounce select, two bits
    localparam int COD_ISEL_LSB = 0;  // current select, two bits

    // configuration register field positions
    localparam int COD_INV_BIT  = 0;  // polarity invert

    // values after reset
    localparam logic [7:0] COD_CTRL_RST = 8'h00;
    localparam logic [7:0] COD_CFG_RST  = 8'h00;

    // debounce select encodings
    localparam logic [1:0] COD_DSEL_NONE = 2'h0;
    localparam logic [1:0] COD_DSEL_S32  = 2'h1;
    localparam logic [1:0] COD_DSEL_S64  = 2'h2;
    localparam logic [1:0] COD_DSEL_S127 = 2'h3;

    // previous samples that must match the current one (N)
    localparam logic [6:0] COD_RUN_S32  = 7'h1F;  // 32 samples in all
    localparam logic [6:0] COD_RUN_S64  = 7'h3F;  // 64 samples in all
    localparam logic [6:0] COD_RUN_S127 = 7'h7E;  // 127 samples in all
    localparam logic [6:0] COD_RUN_MAX  = 7'h7F;  // counter saturation

    // whole state of the block, registered as one word
    typedef struct packed {
        logic        en;       // comparator enable
        logic [1:0]  dsel;     // debounce select
        logic [1:0]  isel;     // current select, passed to analog core
        logic        inv;      // polarity invert
        logic        pol;      // polarity-adjusted sample
        logic        deb;      // debounced output
        logic [6:0]  run;      // previous samples equal to current one
        logic [31:0] prdata;   // read data for the access phase
        logic        pready;   // access phase answer
        logic        pslverr;  // unmapped address answer
    } cod_state_t;

endpackage

// ==== rtl/cod_top.sv ====
// Purpose: digital control and output conditioning of one line comparator
// Assumes: comparator core output is synchronous to pclk (high when + above -)
// Notes:   every APB access has exactly one access cycle; no wait states
//          the filter counts samples that agree with the newest one, so a glitch
//          shorter than the selected run never reaches the debounced output
`timescale 1ns/1ps
module cod_top (
    input  wire logic        pclk,               // system clock, 40 MHz
    input  wire logic        presetn,            // async reset, active low
    input  wire logic        psel,               // APB select
    input  wire logic        penable,            // APB access phase
    input  wire logic        pwrite,             // APB direction, 1 = write
    input  wire logic [7:0]  paddr,              // APB byte address
    input  wire logic [31:0] pwdata,             // APB write data
    output logic      [31:0] prdata,             // APB read data
    output logic             pready,             // APB ready
    output logic             pslverr,            // APB error on unmapped address
    input  wire logic        cmp_raw_in,         // analog core result
    output logic             cmp_enable_bit,     // power control to analog core
    output logic      [1:0]  cmp_current_select, // bias current to analog core
    output logic             cmp_polarised_out,  // polarity-adjusted flag
    output logic             cmp_debounced_out   // filtered flag
);
    import cod_pkg::*;

    cod_state_t state_ff;   // registered state
    cod_state_t nxt_state;  // next state
    logic       wr_ctrl;    // write strobe to control register
    logic       wr_cfg;     // write strobe to configuration register
    logic       raw_gated;  // comparator result after enable gating
    logic [6:0] run_limit;  // required previous matching samples

    // run length for a debounce code; zero when filtering is off
    // a limit of zero would make the filter a plain copy of the flag
    function automatic logic [6:0] limit_of(input logic [1:0] sel);
        logic [6:0] lim;
        lim = 7'h00;
        case (sel)
            COD_DSEL_S32:  lim = COD_RUN_S32;
            COD_DSEL_S64:  lim = COD_RUN_S64;
            COD_DSEL_S127: lim = COD_RUN_S127;
            default:       lim = 7'h00;
        endcase
        return lim;
    endfunction

    // writes land only at the completing edge of the access phase
    assign wr_ctrl = psel && penable && state_ff.pready && pwrite && (paddr == COD_OFS_CTRL);
    assign wr_cfg  = psel && penable && state_ff.pready && pwrite && (paddr == COD_OFS_CFG);

    // a disabled comparator gives 0 whatever the inputs do
    assign raw_gated = state_ff.en & cmp_raw_in;  // RULE1
    assign run_limit = limit_of(state_ff.dsel);

    // next-state logic: registers, sampling, filter and bus answer
    // the whole block is one state word, so every output below is a flip-flop
    // and the bus answer is prepared one cycle ahead of the access phase;
    // the filter is symmetric: rising and falling flags need the same run,
    // which trades a little latency on release for immunity to chatter
    always_comb begin
        nxt_state = state_ff;

        // control fields; out, debounced and bit 4 are not writable
        if (wr_ctrl) begin
            nxt_state.en   = pwdata[COD_EN_BIT];                      // RULE1 RULE7
            nxt_state.dsel = pwdata[COD_DSEL_LSB +: 2];               // RULE4 RULE7
            nxt_state.isel = pwdata[COD_ISEL_LSB +: 2];               // RULE7
        end
        if (wr_cfg) begin
            nxt_state.inv = pwdata[COD_INV_BIT];
        end

        // polarity: disabled gives 0 or 1 per inversion setting
        nxt_state.pol = raw_gated ^ state_ff.inv;                     // RULE2 RULE6

        // count previous samples that agree with the new one
        // saturating, not wrapping, keeps a long steady level counted as a
        // full run, so the output never stalls behind a wrapped counter
        if (nxt_state.pol != state_ff.pol) begin
            nxt_state.run = 7'h00;                                    // RULE3
        end else if (state_ff.run != COD_RUN_MAX) begin
            nxt_state.run = state_ff.run + 7'h01;                     // RULE3
        end

        // follow at once when off, else only after a full matching run
        if (state_ff.dsel == COD_DSEL_NONE) begin
            nxt_state.deb = nxt_state.pol;                            // RULE4
        end else if (nxt_state.run >= run_limit) begin
            nxt_state.deb = nxt_state.pol;                            // RULE3 RULE4
        end

        // bus answer is prepared in the setup cycle, shown in the access cycle
        // read data is a snapshot of the state at the setup edge; a flag that
        // moves during the access cycle shows up on the next read
        nxt_state.pready  = psel && !penable;
        nxt_state.pslverr = 1'b0;
        nxt_state.prdata  = 32'h0000_0000;
        if (psel && !penable) begin
            if (paddr == COD_OFS_CTRL) begin
                nxt_state.prdata[COD_OUT_BIT]       = state_ff.pol;   // RULE7
                nxt_state.prdata[COD_EN_BIT]        = state_ff.en;
                nxt_state.prdata[COD_DEB_BIT]       = state_ff.deb;   // RULE7
                nxt_state.prdata[COD_RSVD_BIT]      = 1'b0;           // RULE5
                nxt_state.prdata[COD_DSEL_LSB +: 2] = state_ff.dsel;
                nxt_state.prdata[COD_ISEL_LSB +: 2] = state_ff.isel;
            end else if (paddr == COD_OFS_CFG) begin
                nxt_state.prdata[COD_INV_BIT] = state_ff.inv;
            end else begin
                // unmapped: zero data and an error flag, nothing stored
                nxt_state.pslverr = 1'b1;
            end
        end
    end

    // single state register; reset values are constants only
    // the async branch loads constants only, so release needs no settling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff         <= '0;
            state_ff.en      <= COD_CTRL_RST[COD_EN_BIT];             // RULE7
            state_ff.dsel    <= COD_CTRL_RST[COD_DSEL_LSB +: 2];      // RULE7
            state_ff.isel    <= COD_CTRL_RST[COD_ISEL_LSB +: 2];      // RULE7
            state_ff.inv     <= COD_CFG_RST[COD_INV_BIT];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // every output straight from the state register
    // no logic sits between these flip-flops and the pins
    assign prdata             = state_ff.prdata;
    assign pready             = state_ff.pready;
    assign pslverr            = state_ff.pslverr;
    assign cmp_enable_bit     = state_ff.en;
    assign cmp_current_select = state_ff.isel;
    assign cmp_polarised_out  = state_ff.pol;
    assign cmp_debounced_out  = state_ff.deb;

    // ------------------------------------------------------------------
    // checks on the block's own outputs
    // all checks run on pclk and are off while presetn is low; the bus checks
    // expect a master that keeps penable high in the cycle after each setup,
    // as every compliant master does
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completing write to the control register
    sequence s_ctrl_write;
        psel && penable && pready && pwrite && (paddr == COD_OFS_CTRL);
    endsequence

    // setup cycle of a control register read
    sequence s_ctrl_read_setup;
        psel && !penable && !pwrite && (paddr == COD_OFS_CTRL);
    endsequence

    // enable output takes the written bit one edge after the write
    property p_enable_write;
        s_ctrl_write |=> (cmp_enable_bit == $past(pwdata[COD_EN_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write) // RULE1
        else $error("enable bit did not follow control write");

    // disabled comparator shows the polarity setting only
    property p_disabled_flag;
        !cmp_enable_bit |=> (cmp_polarised_out == $past(state_ff.inv));
    endproperty
    a_disabled_flag: assert property (p_disabled_flag) // RULE2
        else $error("disabled comparator flag not equal to polarity");

    // enabled comparator shows the input result, inverted when asked
    property p_flag_polarity;
        cmp_enable_bit |=> (cmp_polarised_out == ($past(cmp_raw_in) ^ $past(state_ff.inv)));
    endproperty
    a_flag_polarity: assert property (p_flag_polarity) // RULE6
        else $error("flag does not match polarity-adjusted input");

    // a filtered change needs the full matching run behind it
    property p_debounce_run;
        ($past(state_ff.dsel) != COD_DSEL_NONE) && $changed(cmp_debounced_out)
            |-> (state_ff.run >= limit_of($past(state_ff.dsel))) && (cmp_debounced_out == cmp_polarised_out);
    endproperty
    a_debounce_run: assert property (p_debounce_run) // RULE3
        else $error("debounced output changed before matching run");

    // with filtering off the debounced output tracks the flag
    property p_no_debounce;
        (state_ff.dsel == COD_DSEL_NONE) |=> (cmp_debounced_out == cmp_polarised_out);
    endproperty
    a_no_debounce: assert property (p_no_debounce) // RULE4
        else $error("unfiltered output does not track flag");

    // a full 32-sample run with code 01 has been taken over
    // unless the flag moved again, which restarts the run
    property p_run32_done;
        (state_ff.dsel == COD_DSEL_S32) && (state_ff.run >= COD_RUN_S32)
            ##1 (state_ff.dsel == COD_DSEL_S32) && (state_ff.run != 7'h00)
            |-> (cmp_debounced_out == cmp_polarised_out);
    endproperty
    a_run32_done: assert property (p_run32_done) // RULE4
        else $error("debounced output missed a complete 32-sample run");

    // reserved control bit always reads back zero
    property p_reserved_zero;
        s_ctrl_read_setup |=> pready && (prdata[COD_RSVD_BIT] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // RULE5
        else $error("reserved control bit read as one");

    // status bits read back the live flags, not written values
    property p_status_readback;
        s_ctrl_read_setup |=> (prdata[COD_OUT_BIT] == $past(cmp_polarised_out))
            && (prdata[COD_DEB_BIT] == $past(cmp_debounced_out));
    endproperty
    a_status_readback: assert property (p_status_readback) // RULE7
        else $error("status bits do not reflect comparator flags");

    // any setup cycle, whatever the address
    sequence s_setup;
        psel && !penable;
    endsequence

    // setup cycle whose address hits no register
    sequence s_unmapped_setup;
        psel && !penable && (paddr != COD_OFS_CTRL) && (paddr != COD_OFS_CFG);
    endsequence

    // completing write to an address that hits no register
    sequence s_unmapped_write;
        psel && penable && pready && pwrite && (paddr != COD_OFS_CTRL) && (paddr != COD_OFS_CFG);
    endsequence

    // completing write to the configuration register
    sequence s_cfg_write;
        psel && penable && pready && pwrite && (paddr == COD_OFS_CFG);
    endsequence

    // every setup cycle is answered in the very next cycle
    property p_ready_answer;
        s_setup |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) // RULE7
        else $error("setup cycle not answered in the next cycle");

    // the answer is a one-cycle pulse, never stretched into a second access
    property p_ready_single;
        pready && penable |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single) // RULE7
        else $error("ready stood for more than one cycle");

    // an idle bus sees no answer, no error and zero read data
    property p_idle_quiet;
        !psel |=> !pready && !pslverr && (prdata == 32'h0000_0000);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) // RULE7
        else $error("bus answer shown without a setup cycle");

    // an unmapped address is refused with an error and zero data
    property p_unmapped_error;
        s_unmapped_setup |=> pready && pslverr && (prdata == 32'h0000_0000);
    endproperty
    a_unmapped_error: assert property (p_unmapped_error) // RULE7
        else $error("unmapped access not refused");

    // a refused write leaves enable, current select and polarity as they were
    property p_unmapped_ignored;
        s_unmapped_write
            |=> $stable(cmp_enable_bit) && $stable(cmp_current_select) && $stable(state_ff.inv);
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) // RULE7
        else $error("unmapped write changed a control field");

    // the bias select output takes the written field one edge later
    property p_current_write;
        s_ctrl_write |=> (cmp_current_select == $past(pwdata[COD_ISEL_LSB +: 2]));
    endproperty
    a_current_write: assert property (p_current_write) // RULE7
        else $error("current select did not follow control write");

    // the polarity setting takes the written bit one edge later
    property p_cfg_write;
        s_cfg_write |=> (state_ff.inv == $past(pwdata[COD_INV_BIT]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) // RULE6
        else $error("polarity setting did not follow configuration write");

    // outside a control write the power and bias outputs hold still
    property p_control_hold;
        !(psel && penable && pready && pwrite && (paddr == COD_OFS_CTRL))
            |=> $stable(cmp_enable_bit) && $stable(cmp_current_select);
    endproperty
    a_control_hold: assert property (p_control_hold) // RULE7
        else $error("control output moved without a control write");

    // a filtered output holds until the matching run is complete
    property p_debounce_hold;
        ($past(state_ff.dsel) != COD_DSEL_NONE) && (state_ff.run < limit_of($past(state_ff.dsel)))
            |-> $stable(cmp_debounced_out);
    endproperty
    a_debounce_hold: assert property (p_debounce_hold) // RULE3
        else $error("debounced output moved inside an incomplete run");

endmodule // cod_top

// ==== test/cod_core_model.sv ====
// Purpose: behavioural analog comparator core facing cod_top
// Assumes: core result settles within one pclk and is seen synchronously
// Notes:   levels are plain codes; a tie counts as not above
`timescale 1ns/1ps
module cod_core_model (
    input  wire logic       pclk,           // system clock
    input  wire logic       cmp_enable_bit, // power control from the block
    input  wire logic [9:0] pos_lvl,        // positive input level
    input  wire logic [9:0] neg_lvl,        // negative input level
    output logic            cmp_raw_in      // result to the block
);
    // unpowered core gives 0; otherwise high when positive is above negative
    always @(posedge pclk) begin
        cmp_raw_in <= cmp_enable_bit && (pos_lvl > neg_lvl);
    end
endmodule // cod_core_model

// ==== test/cod_top_tb.sv ====
// Purpose: self-checking bench for cod_top
// Assumes: APB answers come when pready is seen; core model synchronous
// Notes:   reads are scored from a queue by a monitor at the edge that ends them
`timescale 1ns/1ps
module cod_top_tb;
    import cod_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, cmp_raw_in, cmp_enable_bit, cmp_polarised_out, cmp_debounced_out;
    logic [1:0]  cmp_current_select;
    logic [9:0]  pos_lvl = 10'h000, neg_lvl = 10'h000; // analog levels
    logic [32:0] exp_q[$];                             // expected {pslverr, prdata}
    int          n_mismatch = 0, samples_checked = 0, seed = 71, n;
    int          runs[4] = '{0, 31, 63, 126};          // previous samples per code
    always #12.5 pclk = ~pclk; // 40 MHz
    cod_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_raw_in(cmp_raw_in), .cmp_enable_bit(cmp_enable_bit), .cmp_current_select(cmp_current_select),
        .cmp_polarised_out(cmp_polarised_out), .cmp_debounced_out(cmp_debounced_out));
    cod_core_model core (.pclk(pclk), .cmp_enable_bit(cmp_enable_bit), .pos_lvl(pos_lvl),
        .neg_lvl(neg_lvl), .cmp_raw_in(cmp_raw_in));
    task check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // a wait that ran out ends the run as a failure
    task timed_out;
        n_mismatch++;
        complete_run;
    endtask
    // one transfer; holds the request until pready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) timed_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    // read results are taken at the rising edge that samples pready high
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : {33{1'bx}});
        end
    end
    // set levels so that the polarised flag should become tgt
    task drive(input logic tgt, input logic inv);
        @(posedge pclk);
        pos_lvl <= (tgt ^ inv) ? 10'h300 : 10'h100;
        neg_lvl <= 10'h200;
    endtask
    // drive the flag to tgt, then time the filter in clocks
    task measure(input logic tgt, input logic inv, input int want);
        int i;
        drive(tgt, inv);
        i = 0;
        do begin
            @(negedge pclk);
            i++;
        end while (cmp_polarised_out !== tgt && i < 10);
        if (i >= 10) timed_out;
        n = 0;
        while (cmp_debounced_out !== tgt) begin
            @(negedge pclk);
            n++;
            if (n > 200) timed_out;
        end
        check(n, want);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(COD_OFS_CTRL, 33'h0);
        rd(COD_OFS_CFG, 33'h0);
        rd(8'h08, {1'b1, 32'h0});
        apb(1'b1, 8'h08, 32'hFFFFFFFF);
        rd(COD_OFS_CFG, 33'h0);
        apb(1'b1, COD_OFS_CTRL, 32'hFFFFFFFF);
        rd(COD_OFS_CTRL, 33'h4F);
        @(negedge pclk);
        check({cmp_enable_bit, cmp_current_select}, 3'h7);
        // random levels, every enable and polarity pair, no filtering
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, COD_OFS_CFG, {31'h0, k[0]});
            apb(1'b1, COD_OFS_CTRL, {25'h0, k[1], 6'h00});
            pos_lvl <= 10'($random(seed));
            neg_lvl <= 10'($random(seed));
            repeat (3) @(negedge pclk);
            check(cmp_polarised_out, (k[1] && pos_lvl > neg_lvl) ^ k[0]);
            check(cmp_debounced_out, (k[1] && pos_lvl > neg_lvl) ^ k[0]);
        end
        // each filter length, inverting polarity on odd codes
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, COD_OFS_CFG, {31'h0, c[0]});
            apb(1'b1, COD_OFS_CTRL, {25'h0, 1'b1, 2'h0, c[1:0], 2'h0});
            drive(1'b0, c[0]);
            repeat (140) @(negedge pclk);
            check({cmp_polarised_out, cmp_debounced_out}, 2'h0);
            measure(1'b1, c[0], runs[c]);
            rd(COD_OFS_CTRL, {25'h0, 3'h7, 1'b0, c[1:0], 2'h0});
            measure(1'b0, c[0], runs[c]);
        end
        // a second reset in mid-run clears every field again
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(COD_OFS_CTRL, 33'h0);
        rd(COD_OFS_CFG, 33'h0);
        @(negedge pclk);
        check({cmp_enable_bit, cmp_current_select, cmp_debounced_out}, 4'h0);
        complete_run;
    end
endmodule // cod_top_tb
